// ==== hw/clk_src_pkg.sv ====
// constants, types and helpers shared by the cpu clock source block
package clk_src_pkg;

  localparam logic [2:0] CFG_PRESCALE = 3'h1;
  localparam logic [2:0] CFG_DIRECT = 3'h3;
  localparam logic [2:0] CFG_DEFAULT = 3'h7;

  localparam int CLK_FREQ_KHZ = 10000;
  localparam int PLL_FREE_FREQ_KHZ = 5000;
  localparam int PLL_FREE_HALF_CYCLES = CLK_FREQ_KHZ / (2 * PLL_FREE_FREQ_KHZ);
  localparam logic [3:0] PLL_FREE_HALF_LAST = 4'(PLL_FREE_HALF_CYCLES - 1);

  localparam logic [4:0] WD_OVERFLOW_LAST = 5'h0f;
  localparam logic [2:0] SYNC_SETTLE_LAST = 3'h4;

  localparam int PERIOD_W = 12;
  localparam logic [PERIOD_W-1:0] PERIOD_INIT = 12'h008;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 12'hfff;

  typedef enum logic [1:0] {
    MODE_PLL = 2'b00,
    MODE_DIRECT = 2'b01,
    MODE_PRESCALE = 2'b10
  } clk_mode_t;

  typedef struct packed {
    logic [2:0] cfg;
    logic captured;
    logic [2:0] cap_wait;
    clk_mode_t mode;
    logic pll_on;
    logic pll_free;
    logic [3:0] free_cnt;
    logic [4:0] wd_cnt;
    logic fail;
    logic switched;
    logic irq;
    logic cpu_clk;
    logic in_prev;
    logic [PERIOD_W-1:0] per_cnt;
    logic [PERIOD_W-1:0] per_meas;
    logic [PERIOD_W-1:0] acc;
  } clk_state_t;

  localparam clk_state_t STATE_RESET = '{
    cfg: CFG_DEFAULT, captured: 1'b0, cap_wait: 3'h0, mode: MODE_PLL,
    pll_on: 1'b0, pll_free: 1'b0, free_cnt: 4'h0, wd_cnt: 5'h00,
    fail: 1'b0, switched: 1'b0, irq: 1'b0, cpu_clk: 1'b0, in_prev: 1'b0,
    per_cnt: 12'h000, per_meas: PERIOD_INIT, acc: 12'h000};

  // twice the factor, so that 0.5, 1.5 and 2.5 stay integers
  function automatic logic [3:0] factor_x2(input logic [2:0] cfg);
    logic [3:0] f;
    f = 4'h8;
    case (cfg)
      3'h7: f = 4'h8;
      3'h6: f = 4'h6;
      3'h5: f = 4'h4;
      3'h4: f = 4'ha;
      3'h3: f = 4'h2;
      3'h2: f = 4'h3;
      3'h1: f = 4'h1;
      default: f = 4'h5;
    endcase
    return f;
  endfunction

endpackage

// ==== hw/pin_sync.sv ====
// three-stage pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t r;
  sync_state_t n;

  always_comb begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.stable[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.stable;
endmodule // pin_sync

// ==== hw/cpu_clk_source.sv ====
// cpu clock source selection with oscillator watchdog and pll fallback
`timescale 1ns/1ns
module cpu_clk_source
  import clk_src_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clock_input_pin,
  input wire logic [2:0] clock_config_pins,
  input wire logic osc_watchdog_disable,
  output logic cpu_clk,
  output logic pll_enable,
  output logic osc_fail_irq,
  output logic clock_fallback,
  output clk_mode_t clock_mode
);
  logic [3:0] sync_q;
  logic clk_s;
  logic [2:0] cfg_s;
  clk_state_t r;
  clk_state_t n;
  logic edge_any;
  logic clk_rise;
  logic free_rise;
  logic wd_active;
  logic [PERIOD_W:0] acc_sum;
  logic [PERIOD_W:0] per_avg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  pin_sync #(.WIDTH(4)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d({clock_config_pins, clock_input_pin}),
    .q(sync_q)
  );

  assign clk_s = sync_q[0];
  assign cfg_s = sync_q[3:1];

  always_comb begin
    n = r;
    n.irq = 1'b0;
    edge_any = 1'b0;
    clk_rise = 1'b0;
    free_rise = 1'b0;
    wd_active = 1'b0;
    acc_sum = '0;
    per_avg = '0;
    if (!r.captured) begin
      // pins sampled once the synchroniser has settled after release
      if (r.cap_wait == SYNC_SETTLE_LAST) begin
        n.captured = 1'b1;
        n.cfg = cfg_s;
        n.in_prev = clk_s;
        if (cfg_s == CFG_PRESCALE) begin
          n.mode = MODE_PRESCALE;
        end else if (cfg_s == CFG_DIRECT) begin
          n.mode = MODE_DIRECT;
        end else begin
          n.mode = MODE_PLL;
        end
      end else begin
        n.cap_wait = r.cap_wait + 3'h1;
      end
    end else begin
      edge_any = clk_s != r.in_prev;
      clk_rise = clk_s && !r.in_prev;
      n.in_prev = clk_s;
      // pll needed as multiplier, as watchdog timebase, or as fallback clock
      n.pll_on = (r.mode == MODE_PLL) || !osc_watchdog_disable || r.fail;
      if (n.pll_on) begin
        if (r.free_cnt == PLL_FREE_HALF_LAST) begin
          n.free_cnt = 4'h0;
          n.pll_free = !r.pll_free;
        end else begin
          n.free_cnt = r.free_cnt + 4'h1;
        end
      end else begin
        n.free_cnt = 4'h0;
        n.pll_free = 1'b0;
      end
      free_rise = n.pll_free && !r.pll_free;
      // watchdog only guards the modes where the input drives the cpu
      wd_active = (r.mode != MODE_PLL) && !osc_watchdog_disable && !r.fail;
      if (!wd_active) begin
        n.wd_cnt = 5'h00;
      end else if (edge_any) begin
        n.wd_cnt = 5'h00;
      end else if (free_rise) begin
        if (r.wd_cnt == WD_OVERFLOW_LAST) begin
          n.wd_cnt = 5'h00;
          n.fail = 1'b1;
          n.irq = 1'b1;
        end else begin
          n.wd_cnt = r.wd_cnt + 5'h01;
        end
      end
      if (r.switched) begin
        n.cpu_clk = n.pll_free;
      end else if (r.fail) begin
        // park low and join the pll clock only at a low phase, so no runt pulse
        n.cpu_clk = 1'b0;
        if (!r.cpu_clk && !r.pll_free) begin
          n.switched = 1'b1;
        end
      end else begin
        case (r.mode)
          MODE_DIRECT: begin
            n.cpu_clk = clk_s;
          end
          MODE_PRESCALE: begin
            if (clk_rise) begin
              n.cpu_clk = !r.cpu_clk;
            end
          end
          default: begin
            // measured input period is blended in by halves, so lock drifts
            if (r.per_cnt != PERIOD_MAX) begin
              n.per_cnt = r.per_cnt + 12'h001;
            end
            if (clk_rise) begin
              // round towards the new measurement, else the estimate parks one short
              per_avg = ({1'b0, r.per_meas} + {1'b0, r.per_cnt}
                + {{PERIOD_W{1'b0}}, r.per_cnt > r.per_meas}) >> 1;
              n.per_meas = (per_avg[PERIOD_W-1:0] == 12'h000) ? 12'h001
                : per_avg[PERIOD_W-1:0];
              n.per_cnt = 12'h001;
            end
            // limitation: output toggles at most once per mclk cycle
            acc_sum = {1'b0, r.acc} + {9'h000, factor_x2(r.cfg)};
            if (acc_sum >= {1'b0, r.per_meas}) begin
              n.acc = PERIOD_W'(acc_sum - {1'b0, r.per_meas});
              n.cpu_clk = !r.cpu_clk;
            end else begin
              n.acc = acc_sum[PERIOD_W-1:0];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= STATE_RESET;
    end else begin
      r <= n;
    end
  end

  assign cpu_clk = r.cpu_clk;
  assign pll_enable = r.pll_on;
  assign osc_fail_irq = r.irq;
  assign clock_fallback = r.switched;
  assign clock_mode = r.mode;

  property p_prescale_toggle;
    r.captured && r.mode == MODE_PRESCALE && !r.fail && clk_rise && !n.fail
      |=> r.cpu_clk != $past(r.cpu_clk);
  endproperty
  a_prescale_toggle: assert property (p_prescale_toggle)
    else $error("prescaler did not toggle on input rise");

  property p_prescale_hold;
    r.captured && r.mode == MODE_PRESCALE && !r.fail && !clk_rise && !n.fail
      |=> $stable(r.cpu_clk);
  endproperty
  a_prescale_hold: assert property (p_prescale_hold)
    else $error("prescaler changed without input rise");

  property p_direct_follow;
    r.captured && r.mode == MODE_DIRECT && !r.fail && !n.fail
      |=> r.cpu_clk == $past(clk_s);
  endproperty
  a_direct_follow: assert property (p_direct_follow)
    else $error("direct mode cpu clock not following input");

  property p_pll_power;
    r.captured && r.mode != MODE_PLL && !r.fail
      |=> r.pll_on == !$past(osc_watchdog_disable);
  endproperty
  a_pll_power: assert property (p_pll_power)
    else $error("pll power does not match watchdog disable");

  property p_wd_overflow;
    wd_active && !edge_any && free_rise && r.wd_cnt == WD_OVERFLOW_LAST
      |=> r.fail && r.irq ##1 !r.irq;
  endproperty
  a_wd_overflow: assert property (p_wd_overflow)
    else $error("watchdog overflow did not raise failure");

  property p_wd_clear;
    wd_active && edge_any |=> r.wd_cnt == 5'h00;
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("input transition did not clear watchdog");

  property p_wd_count;
    wd_active && !edge_any && free_rise && r.wd_cnt != WD_OVERFLOW_LAST
      |=> r.wd_cnt == $past(r.wd_cnt) + 5'h01;
  endproperty
  a_wd_count: assert property (p_wd_count)
    else $error("watchdog counter did not advance");

  property p_fail_sticky;
    $rose(r.fail) |-> ##[1:4] r.switched ##1 (r.fail && r.switched) [*8];
  endproperty
  a_fail_sticky: assert property (p_fail_sticky)
    else $error("fallback not reached or not held");

  property p_irq_cause;
    r.irq |-> r.fail && !$past(r.fail);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq without fresh failure");

  property p_glitch_free;
    $rose(r.switched) |-> $past(r.cpu_clk) == 1'b0 && r.cpu_clk == 1'b0;
  endproperty
  a_glitch_free: assert property (p_glitch_free)
    else $error("switch-over not at a low phase");

  property p_pll_mode_on;
    r.captured && r.mode == MODE_PLL ##1 r.captured |-> r.pll_on;
  endproperty
  a_pll_mode_on: assert property (p_pll_mode_on)
    else $error("pll off in pll mode");

  property p_mode_kept;
    r.captured |=> $stable(r.mode) && $stable(r.cfg);
  endproperty
  a_mode_kept: assert property (p_mode_kept)
    else $error("latched clock mode changed");

  property p_precap_quiet;
    !r.captured |=> !r.pll_on && !r.cpu_clk && !r.fail;
  endproperty
  a_precap_quiet: assert property (p_precap_quiet)
    else $error("clock activity before pins were latched");

  property p_irq_pulse;
    r.irq |=> !r.irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("failure irq longer than one cycle");

  property p_dis_no_fail;
    r.captured && osc_watchdog_disable && !r.fail |=> !r.fail;
  endproperty
  a_dis_no_fail: assert property (p_dis_no_fail)
    else $error("failure raised with watchdog disabled");

  property p_wd_idle_pll;
    r.captured && r.mode == MODE_PLL |=> r.wd_cnt == 5'h00 && !r.fail;
  endproperty
  a_wd_idle_pll: assert property (p_wd_idle_pll)
    else $error("watchdog ran in pll mode");

  property p_free_toggle;
    r.captured && n.pll_on |=> r.pll_free != $past(r.pll_free);
  endproperty
  a_free_toggle: assert property (p_free_toggle)
    else $error("free-running pll clock stalled");

  property p_free_off;
    r.captured && !n.pll_on |=> !r.pll_on && !r.pll_free;
  endproperty
  a_free_off: assert property (p_free_off)
    else $error("pll clock running while powered off");

  property p_switch_follow;
    r.switched |=> r.cpu_clk == r.pll_free;
  endproperty
  a_switch_follow: assert property (p_switch_follow)
    else $error("fallback cpu clock not the pll clock");

  property p_switch_sticky;
    r.switched |=> r.switched && r.fail;
  endproperty
  a_switch_sticky: assert property (p_switch_sticky)
    else $error("fallback released before reset");

  property p_fail_low;
    r.fail && !r.switched |=> !r.cpu_clk;
  endproperty
  a_fail_low: assert property (p_fail_low)
    else $error("cpu clock not parked low before switch-over");

  property p_cfg_capture;
    $rose(r.captured) |-> r.cfg == $past(cfg_s);
  endproperty
  a_cfg_capture: assert property (p_cfg_capture)
    else $error("latched pins differ from synchronised pins");

  property p_per_up;
    r.captured && r.mode == MODE_PLL && clk_rise && r.per_cnt > r.per_meas
      |=> r.per_meas > $past(r.per_meas) && r.per_meas <= $past(r.per_cnt);
  endproperty
  a_per_up: assert property (p_per_up)
    else $error("period estimate did not move up gradually");

  property p_per_down;
    r.captured && r.mode == MODE_PLL && clk_rise && r.per_cnt < r.per_meas
      && r.per_cnt != 12'h000
      |=> r.per_meas < $past(r.per_meas) && r.per_meas >= $past(r.per_cnt);
  endproperty
  a_per_down: assert property (p_per_down)
    else $error("period estimate did not move down gradually");
endmodule // cpu_clk_source

// ==== verification/osc_model.sv ====
// external oscillator model: clock with selectable half period that can stop
`timescale 1ns/1ns
module osc_model (
  input wire logic mclk,
  input wire logic run,
  input wire logic [3:0] half,
  output logic pin
);
  logic [3:0] cnt_q;
  initial begin
    pin = 1'b0;
    cnt_q = 4'h0;
  end
  // a failed crystal freezes at its last level, so the watchdog sees no edge
  always @(posedge mclk) begin
    if (run) begin
      if (cnt_q + 4'h1 >= half) begin
        cnt_q <= 4'h0;
        pin <= ~pin;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule // osc_model

// ==== verification/cpu_clock_source_with_osc_watchdog_tb_top.sv ====
// testbench for the cpu clock source with oscillator watchdog
`timescale 1ns/1ns
module cpu_clock_source_with_osc_watchdog_tb_top;
  import clk_src_pkg::*;
  logic mclk, resetn, osc_run, dis, pin_p, cpu_p;
  logic [2:0] cfg_pins;
  logic [3:0] half;
  wire pin;
  logic cpu_clk, pll_en, irq, fb;
  clk_mode_t mode;
  int err_count, num_checks, seed, cyc, in_e, in_r, cpu_e, irq_n;

  cpu_clk_source i_dut (
    .mclk(mclk), .resetn(resetn), .clock_input_pin(pin), .clock_config_pins(cfg_pins),
    .osc_watchdog_disable(dis), .cpu_clk(cpu_clk), .pll_enable(pll_en),
    .osc_fail_irq(irq), .clock_fallback(fb), .clock_mode(mode));
  osc_model i_osc (.mclk(mclk), .run(osc_run), .half(half), .pin(pin));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // edge counters feed the integer model; reads see pre-edge values
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      end_sim();
    end else begin
      if (pin !== pin_p) in_e++;
      if (pin === 1'b1 && pin_p === 1'b0) in_r++;
      if (cpu_clk !== cpu_p) cpu_e++;
      if (irq === 1'b1) irq_n++;
      pin_p = pin;
      cpu_p = cpu_clk;
    end
  end

  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // edge counts may straddle a window border, so one edge of slack
  task automatic close(string nm, int seen, int exp);
    if (seen >= exp - 1 && seen <= exp + 1)
      check(nm, 8'(exp), 8'(exp));
    else
      check(nm, 8'(seen), 8'(exp));
  endtask

  task automatic wt(int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic win(int n);
    @(negedge mclk);
    in_e = 0;
    in_r = 0;
    cpu_e = 0;
    wt(n);
  endtask

  function automatic int exp_mode(int c);
    return (c == 3) ? 1 : ((c == 1) ? 2 : 0);
  endfunction

  // twice the multiplication factor per pll mode pin pattern, so the halves stay integers
  function automatic int fx2(int c);
    return (c == 7) ? 8 : (c == 6) ? 6 : (c == 5) ? 4 : (c == 4) ? 10 : (c == 2) ? 3 : 5;
  endfunction

  task automatic rst(logic [2:0] c, logic d);
    @(posedge mclk);
    resetn <= 1'b0;
    cfg_pins <= c;
    dis <= d;
    osc_run <= 1'b1;
    half <= 4'(3 + ($unsigned($random(seed)) % 4));
    irq_n = 0;
    wt(5);
    check("rst_fb", 8'(fb), 8'h00);
    check("rst_cpu", 8'(cpu_clk), 8'h00);
    @(posedge mclk);
    resetn <= 1'b1;
    repeat (6) @(posedge mclk);
    cfg_pins <= 3'($random(seed));
    wt(4);
  endtask

  task automatic stop_osc(logic [7:0] fail);
    @(posedge mclk);
    osc_run <= 1'b0;
    wt(25);
    check("irq_early", 8'(irq_n), 8'h00);
    wt(60);
    check("irq", 8'(irq_n), fail);
    check("fb", 8'(fb), fail);
  endtask

  initial begin
    seed = 48;
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    irq_n = 0;
    in_e = 0;
    in_r = 0;
    cpu_e = 0;
    pin_p = 1'b0;
    cpu_p = 1'b0;
    resetn = 1'b0;
    cfg_pins = 3'h7;
    dis = 1'b0;
    osc_run = 1'b0;
    half = 4'h4;
    for (int c = 0; c < 8; c++) begin
      rst(3'(c), 1'b0);
      check("mode", 8'(mode), 8'(exp_mode(c)));
      check("pll_en", 8'(pll_en), 8'h01);
      // let the period estimate settle before counting pll mode edges
      if (exp_mode(c) == 0)
        wt(200);
      win(240);
      check("no_fail", 8'(irq_n), 8'h00);
      if (c == 3)
        close("direct", cpu_e, in_e);
      if (c == 1)
        close("presc", cpu_e, in_r);
      // one toggle per mclk at most, so only unsaturated factors are counted
      if (exp_mode(c) == 0 && fx2(c) <= 2 * int'(half))
        close("pll_freq", cpu_e, 120 * fx2(c) / int'(half));
      stop_osc(8'(exp_mode(c) != 0));
      @(posedge mclk);
      osc_run <= 1'b1;
      wt(40);
      check("fb_hold", 8'(fb), 8'(exp_mode(c) != 0));
      check("irq_once", 8'(irq_n), 8'(exp_mode(c) != 0));
      if (exp_mode(c) != 0) begin
        win(20);
        close("pll_free", cpu_e, 20);
        check("pll_on", 8'(pll_en), 8'h01);
      end
      $display("test config %0d done", c);
    end
    // watchdog disabled: pll off, cpu stays on the crystal, no fallback
    rst(3'h3, 1'b1);
    check("pll_off", 8'(pll_en), 8'h00);
    win(120);
    close("dis_direct", cpu_e, in_e);
    stop_osc(8'h00);
    $display("test watchdog disabled done");
    // disable bit set in mid-run: pll powers down and a stop is ignored
    rst(3'h1, 1'b0);
    @(posedge mclk);
    dis <= 1'b1;
    wt(2);
    check("pll_dis", 8'(pll_en), 8'h00);
    stop_osc(8'h00);
    $display("test watchdog disabled in mid-run done");
    end_sim();
  end
endmodule // cpu_clock_source_with_osc_watchdog_tb_top
